// ---- hdl/dbgs_cfg.svh ----
// Offsets, field positions, reset values and value limits for the gain selector
`ifndef DBGS_CFG_SVH
`define DBGS_CFG_SVH
`define DBGS_OFF_LOW_FRAC   12'h000
`define DBGS_OFF_UP_FRAC    12'h004
`define DBGS_OFF_GAIN1      12'h008
`define DBGS_OFF_GAIN2      12'h00C
`define DBGS_OFF_GAIN3      12'h010
`define DBGS_OFF_GAIN4      12'h014
`define DBGS_OFF_CTRL       12'h018
`define DBGS_OFF_STATUS     12'h01C
`define DBGS_UNSET          16'h270F
`define DBGS_FRAC_LOW_DEF   16'h0021
`define DBGS_FRAC_UP_DEF    16'h0042
`define DBGS_FRAC_MIN       16'h0001
`define DBGS_FRAC_MAX       16'h0063
`define DBGS_GAIN_MAX       16'h03E8
`define DBGS_PCT_DIV        32'h0000_0064
`define DBGS_CTRL_SEL2_BIT  0
`define DBGS_CTRL_VEC_BIT   1
`endif

// ---- hdl/dbgs_pick.sv ----
// Table entry pick for a zone, skipping unset entries
`timescale 1ns/1ps
`default_nettype none
`include "dbgs_cfg.svh"
module dbgs_pick (
   // Table
   input  wire logic [15:0]    g1_i,
   input  wire logic [15:0]    g2_i,
   input  wire logic [15:0]    g3_i,
   input  wire logic [15:0]    g4_i,
   // Selection
   input  wire logic [1:0]     zone_i,
   input  wire logic           equal_i,
   // Result
   output logic [15:0]         gain_o
);
   import dbgs_pkg::*;
   function automatic logic is_set(input logic [15:0] g);
      is_set = (g != `DBGS_UNSET);
   endfunction : is_set
   logic [15:0] mid_g;
   logic [15:0] low_g;
   logic [15:0] up_g;
   logic [15:0] big23;
   assign big23 = (g2_i > g3_i) ? g2_i : g3_i;
   // Nearest set entry, preferring the zone's own side
   assign low_g = is_set(g1_i) ? g1_i : is_set(g2_i) ? g2_i : is_set(g3_i) ? g3_i : g4_i;
   assign up_g  = is_set(g4_i) ? g4_i : is_set(g3_i) ? g3_i : is_set(g2_i) ? g2_i : g1_i;
   assign mid_g = (equal_i && is_set(g2_i) && is_set(g3_i)) ? big23 :
                  is_set(g2_i) ? g2_i : is_set(g3_i) ? g3_i :
                  is_set(g1_i) ? g1_i : g4_i;
   assign gain_o = (zone_i == DBGS_ZONE_LOW) ? low_g :
                   (zone_i == DBGS_ZONE_UP)  ? up_g  : mid_g;
endmodule : dbgs_pick
`default_nettype wire

// ---- hdl/dbgs_pkg.sv ----
// Types shared by the gain selector files
package dbgs_pkg;
   typedef logic [15:0] dbgs_word_t;
   typedef enum logic [1:0] {
      DBGS_ZONE_LOW = 2'b00,
      DBGS_ZONE_MID = 2'b01,
      DBGS_ZONE_UP  = 2'b10
   } dbgs_zone_t;
   typedef enum logic [1:0] {
      DBGS_CTL_OTHER   = 2'b00,
      DBGS_CTL_VECTOR  = 2'b01,
      DBGS_CTL_RSLVEC  = 2'b10
   } dbgs_ctl_mode_t;
endpackage : dbgs_pkg

// ---- hdl/dbgs_thresh.sv ----
// Threshold arithmetic: min plus span times fraction over one hundred
`timescale 1ns/1ps
`default_nettype none
`include "dbgs_cfg.svh"
module dbgs_thresh (
   // Clock and reset
   input  wire logic           clk_i,
   input  wire logic           nrst_i,
   // Operands
   input  wire dbgs_pkg::dbgs_word_t dmin_i,
   input  wire dbgs_pkg::dbgs_word_t dmax_i,
   input  wire dbgs_pkg::dbgs_word_t frac_i,
   input  wire dbgs_pkg::dbgs_word_t frac_def_i,
   // Result
   output logic [15:0]         thr_o
);
   import dbgs_pkg::*;
   logic [15:0] span;
   logic [15:0] frac_eff;
   logic [31:0] prod;
   logic [31:0] quot;
   logic [15:0] thr_d;
   logic [15:0] thr_q;
   // Reversed limits give a zero span rather than a wrapped one
   assign span     = (dmax_i > dmin_i) ? (dmax_i - dmin_i) : 16'h0000;
   assign frac_eff = (frac_i == `DBGS_UNSET) ? frac_def_i : frac_i;
   assign prod     = span * frac_eff;
   assign quot     = prod / `DBGS_PCT_DIV;
   assign thr_d    = dmin_i + quot[15:0];
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         thr_q <= 16'h0000;
      end else begin
         thr_q <= thr_d;
      end
   end
   assign thr_o = thr_q;
endmodule : dbgs_thresh
`default_nettype wire

// ---- hdl/dbgs_top.sv ----
// Diameter based speed-loop proportional gain selector with APB registers
// Notes on behaviour
// - Lower threshold is min diameter plus span times lower fraction over 100; 1..99.
// - Upper threshold is min diameter plus span times upper fraction over 100.
// - Fraction value 9999 acts as 33 percent lower, 66 percent upper.
// - Table gains take 0..1000 percent; 9999 marks an entry unset.
// - Table used only with two or more set entries, else base gain.
// - Equal fractions: larger of table gains two and three applies there.
// - Table selection only under vector or real sensorless vector control, or with the control register's vector force bit set.
// - Diameter calculation off forces base gain whatever the disable input.
// - Calculation on: table when disable input off, base gain when on.
//
// The register offsets and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "dbgs_cfg.svh"
module dbgs_top (
   // Clock and reset
   input  wire logic              clk_i,
   input  wire logic              nrst_i,
   // APB slave
   input  wire logic              psel_i,
   input  wire logic              penable_i,
   input  wire logic              pwrite_i,
   input  wire logic [11:0]       paddr_i,
   input  wire logic [31:0]       pwdata_i,
   output logic [31:0]            prdata_o,
   output logic                   pready_o,
   output logic                   pslverr_o,
   // Diameter calculator side
   input  wire logic [15:0]       diameter_i,
   input  wire logic [15:0]       dmin_i,
   input  wire logic [15:0]       dmax_i,
   input  wire logic              diam_calc_en_i,
   // Base gains and control mode
   input  wire logic [15:0]       base_proportional_gain_i,
   input  wire logic [15:0]       second_base_proportional_gain_i,
   input  wire dbgs_pkg::dbgs_ctl_mode_t ctl_mode_i,
   // Pin from input terminal
   input  wire logic              gain_table_disable_input_i,
   // Speed loop side
   output logic [15:0]            speed_p_gain_o,
   output logic                   table_active_o
);
   import dbgs_pkg::*;

   function automatic logic frac_ok(input logic [31:0] v);
      frac_ok = (v[15:0] == `DBGS_UNSET) ||
                ((v[31:16] == 16'h0000) && (v[15:0] >= `DBGS_FRAC_MIN) && (v[15:0] <= `DBGS_FRAC_MAX));
   endfunction : frac_ok

   function automatic logic gain_ok(input logic [31:0] v);
      gain_ok = (v[31:16] == 16'h0000) &&
                ((v[15:0] == `DBGS_UNSET) || (v[15:0] <= `DBGS_GAIN_MAX));
   endfunction : gain_ok

   function automatic logic [1:0] set_cnt(input logic a, input logic b, input logic c, input logic d);
      set_cnt = 2'(a) + 2'(b) + 2'(c) + 2'(d);
   endfunction : set_cnt

   ////////////////////////////////////////////////////////////////////////////////
   // Registers
   logic [15:0] low_frac_q;
   logic [15:0] up_frac_q;
   logic [15:0] gain1_q;
   logic [15:0] gain2_q;
   logic [15:0] gain3_q;
   logic [15:0] gain4_q;
   logic        sel2_q;
   logic        vec_force_q;
   logic [31:0] prdata_q;
   logic        pready_q;
   logic        pslverr_q;

   wire  acc    = psel_i && penable_i && !pready_q;
   wire  wr     = acc && pwrite_i;
   wire  a_lf   = (paddr_i == `DBGS_OFF_LOW_FRAC);
   wire  a_uf   = (paddr_i == `DBGS_OFF_UP_FRAC);
   wire  a_g1   = (paddr_i == `DBGS_OFF_GAIN1);
   wire  a_g2   = (paddr_i == `DBGS_OFF_GAIN2);
   wire  a_g3   = (paddr_i == `DBGS_OFF_GAIN3);
   wire  a_g4   = (paddr_i == `DBGS_OFF_GAIN4);
   wire  a_ct   = (paddr_i == `DBGS_OFF_CTRL);
   wire  a_st   = (paddr_i == `DBGS_OFF_STATUS);
   wire  a_gain = a_g1 || a_g2 || a_g3 || a_g4;
   wire  a_frac = a_lf || a_uf;
   wire  mapped = a_frac || a_gain || a_ct || a_st;
   // Out of range writes are refused whole so a bad value never reaches the loop
   wire  bad_wr = pwrite_i && ((a_frac && !frac_ok(pwdata_i)) || (a_gain && !gain_ok(pwdata_i)) || a_st);
   wire  err    = !mapped || bad_wr;
   wire  wr_ok  = wr && !err;

   ////////////////////////////////////////////////////////////////////////////////
   // Selection datapath
   logic [15:0] thr_low;
   logic [15:0] thr_up;
   logic [15:0] tbl_gain;
   logic [1:0]  din_s1_q;
   logic [1:0]  din_s2_q;
   logic [15:0] gain_q;
   logic        tact_q;

   wire  s1 = (gain1_q != `DBGS_UNSET);
   wire  s2 = (gain2_q != `DBGS_UNSET);
   wire  s3 = (gain3_q != `DBGS_UNSET);
   wire  s4 = (gain4_q != `DBGS_UNSET);
   wire [1:0] n_set = set_cnt(s1, s2, s3, s4);
   wire  enough   = (n_set >= 2'd2) || (s1 && s2 && s3 && s4);
   wire  vec_mode = (ctl_mode_i == DBGS_CTL_VECTOR) || (ctl_mode_i == DBGS_CTL_RSLVEC) || vec_force_q;
   wire  dis_pin  = din_s2_q[0];
   wire  use_tbl  = diam_calc_en_i && !dis_pin && enough && vec_mode;
   wire  frac_eq  = (low_frac_q == up_frac_q);
   wire [1:0] zone = (diameter_i < thr_low) ? DBGS_ZONE_LOW :
                     (diameter_i > thr_up)  ? DBGS_ZONE_UP  : DBGS_ZONE_MID;
   wire [15:0] base_g = sel2_q ? second_base_proportional_gain_i : base_proportional_gain_i;
   wire [15:0] gain_d = use_tbl ? tbl_gain : base_g;

   dbgs_thresh u_thr_low (
      .clk_i      (clk_i),
      .nrst_i     (nrst_i),
      .dmin_i     (dmin_i),
      .dmax_i     (dmax_i),
      .frac_i     (low_frac_q),
      .frac_def_i (`DBGS_FRAC_LOW_DEF),
      .thr_o      (thr_low)
   );

   dbgs_thresh u_thr_up (
      .clk_i      (clk_i),
      .nrst_i     (nrst_i),
      .dmin_i     (dmin_i),
      .dmax_i     (dmax_i),
      .frac_i     (up_frac_q),
      .frac_def_i (`DBGS_FRAC_UP_DEF),
      .thr_o      (thr_up)
   );

   dbgs_pick u_pick (
      .g1_i    (gain1_q),
      .g2_i    (gain2_q),
      .g3_i    (gain3_q),
      .g4_i    (gain4_q),
      .zone_i  (zone),
      .equal_i (frac_eq),
      .gain_o  (tbl_gain)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Read mux
   wire [31:0] rd_d = a_lf ? {16'h0000, low_frac_q} :
                      a_uf ? {16'h0000, up_frac_q} :
                      a_g1 ? {16'h0000, gain1_q} :
                      a_g2 ? {16'h0000, gain2_q} :
                      a_g3 ? {16'h0000, gain3_q} :
                      a_g4 ? {16'h0000, gain4_q} :
                      a_ct ? {30'h0, vec_force_q, sel2_q} :
                      a_st ? {8'h00, zone, n_set, 1'b0, dis_pin, enough, tact_q, gain_q} :
                      32'h0000_0000;

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= 32'h0000_0000;
      end else begin
         pready_q  <= acc;
         pslverr_q <= acc && err;
         prdata_q  <= (acc && !pwrite_i && mapped) ? rd_d : 32'h0000_0000;
      end
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         low_frac_q  <= `DBGS_UNSET;
         up_frac_q   <= `DBGS_UNSET;
         gain1_q     <= `DBGS_UNSET;
         gain2_q     <= `DBGS_UNSET;
         gain3_q     <= `DBGS_UNSET;
         gain4_q     <= `DBGS_UNSET;
         sel2_q      <= 1'b0;
         vec_force_q <= 1'b0;
      end else if (wr_ok) begin
         if (a_lf) low_frac_q <= pwdata_i[15:0];
         if (a_uf) up_frac_q  <= pwdata_i[15:0];
         if (a_g1) gain1_q    <= pwdata_i[15:0];
         if (a_g2) gain2_q    <= pwdata_i[15:0];
         if (a_g3) gain3_q    <= pwdata_i[15:0];
         if (a_g4) gain4_q    <= pwdata_i[15:0];
         if (a_ct) begin
            sel2_q      <= pwdata_i[`DBGS_CTRL_SEL2_BIT];
            vec_force_q <= pwdata_i[`DBGS_CTRL_VEC_BIT];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Terminal synchroniser and output stage
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         din_s1_q <= 2'b00;
         din_s2_q <= 2'b00;
         gain_q   <= 16'h0000;
         tact_q   <= 1'b0;
      end else begin
         din_s1_q <= {1'b0, gain_table_disable_input_i};
         din_s2_q <= din_s1_q;
         gain_q   <= gain_d;
         tact_q   <= use_tbl;
      end
   end

   assign speed_p_gain_o = gain_q;
   assign table_active_o = tact_q;
   assign prdata_o       = prdata_q;
   assign pready_o       = pready_q;
   assign pslverr_o      = pslverr_q;
endmodule : dbgs_top
`default_nettype wire

// ---- tb/dbgs_chk.sv ----
// Port checker for the gain selector
`timescale 1ns/1ps
`default_nettype none
module dbgs_chk (
   // Clock and reset
   input wire logic        clk_i,
   input wire logic        nrst_i,
   // APB
   input wire logic        psel_i,
   input wire logic        penable_i,
   input wire logic        pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [31:0] prdata_o,
   input wire logic        pready_o,
   input wire logic        pslverr_o,
   // Selection
   input wire logic        diam_calc_en_i,
   input wire logic [15:0] base_proportional_gain_i,
   input wire logic [15:0] second_base_proportional_gain_i,
   input wire logic        gain_table_disable_input_i,
   input wire logic [15:0] speed_p_gain_o,
   input wire logic        table_active_o
);
   wire acc = psel_i && penable_i && !pready_o;
   wire wlo = pwdata_i[15:0] != 16'h270F;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!nrst_i);
   ready_pulse_a: assert property (pready_o |=> !pready_o) else $error("ready held");
   ready_answer_a: assert property (acc |=> pready_o) else $error("no answer");
   error_with_ready_a: assert property (pslverr_o |-> pready_o) else $error("stray error");
   idle_rdata_a: assert property (!pready_o |-> prdata_o == 32'h0) else $error("idle data");
   gain_refuse_a: assert property (acc && pwrite_i && paddr_i == 12'h008 && wlo &&
      pwdata_i[15:0] > 16'h03E8 |=> pslverr_o) else $error("gain accepted");
   frac_refuse_a: assert property (acc && pwrite_i && paddr_i == 12'h000 &&
      pwdata_i[15:0] == 16'h0 |=> pslverr_o) else $error("fraction accepted");
   calc_off_a: assert property ($past(nrst_i) && !$past(diam_calc_en_i) |-> !table_active_o)
      else $error("table with calc off");
   base_gain_a: assert property ($past(nrst_i) && !table_active_o |->
      speed_p_gain_o == $past(base_proportional_gain_i) ||
      speed_p_gain_o == $past(second_base_proportional_gain_i)) else $error("not base gain");
   pin_off_a: assert property ($past(nrst_i, 4) && $past(gain_table_disable_input_i, 2) &&
      $past(gain_table_disable_input_i, 3) && $past(gain_table_disable_input_i, 4)
      |-> !table_active_o) else $error("table with pin on");
   table_range_a: assert property (table_active_o |-> speed_p_gain_o <= 16'h03E8)
      else $error("gain out of range");
endmodule : dbgs_chk
`default_nettype wire

// ---- tb/dbgs_partner.sv ----
// Diameter calculator model: registers what it is told, like a sampled result
`timescale 1ns/1ps
`default_nettype none
module dbgs_partner (
   input wire logic        clk_i,
   input wire logic        nrst_i,
   input wire logic [15:0] target_i,
   input wire logic [15:0] min_i,
   input wire logic [15:0] max_i,
   input wire logic        en_i,
   output logic [15:0]     diameter_o,
   output logic [15:0]     dmin_o,
   output logic [15:0]     dmax_o,
   output logic            calc_en_o
);
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         {diameter_o, dmin_o, dmax_o, calc_en_o} <= '0;
      end else begin
         {diameter_o, dmin_o, dmax_o, calc_en_o} <= {target_i, min_i, max_i, en_i};
      end
   end
endmodule : dbgs_partner
`default_nettype wire

// ---- tb/test_dbgs_top.sv ----
// Self-checking bench for the gain selector
`timescale 1ns/1ps
`default_nettype none
module test_dbgs_top;
   import dbgs_pkg::*;
   logic clk_i, nrst_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, err, cen;
   logic diam_calc_en_i, gain_table_disable_input_i, table_active_o;
   logic [11:0] paddr_i;
   logic [31:0] pwdata_i, prdata_o, rd;
   logic [15:0] diameter_i, dmin_i, dmax_i, tgt, lo, hi, speed_p_gain_o;
   logic [15:0] base_proportional_gain_i, second_base_proportional_gain_i;
   dbgs_ctl_mode_t ctl_mode_i;
   int n_fail, compares;
   dbgs_top dut (
      .clk_i                           (clk_i),
      .nrst_i                          (nrst_i),
      .psel_i                          (psel_i),
      .penable_i                       (penable_i),
      .pwrite_i                        (pwrite_i),
      .paddr_i                         (paddr_i),
      .pwdata_i                        (pwdata_i),
      .prdata_o                        (prdata_o),
      .pready_o                        (pready_o),
      .pslverr_o                       (pslverr_o),
      .diameter_i                      (diameter_i),
      .dmin_i                          (dmin_i),
      .dmax_i                          (dmax_i),
      .diam_calc_en_i                  (diam_calc_en_i),
      .base_proportional_gain_i        (base_proportional_gain_i),
      .second_base_proportional_gain_i (second_base_proportional_gain_i),
      .ctl_mode_i                      (ctl_mode_i),
      .gain_table_disable_input_i      (gain_table_disable_input_i),
      .speed_p_gain_o                  (speed_p_gain_o),
      .table_active_o                  (table_active_o)
   );
   dbgs_partner u_far (.clk_i(clk_i), .nrst_i(nrst_i), .target_i(tgt), .min_i(lo), .max_i(hi),
      .en_i(cen), .diameter_o(diameter_i), .dmin_o(dmin_i), .dmax_o(dmax_i),
      .calc_en_o(diam_calc_en_i));
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   ////////////////////////////////////////////////////////////////
   task check(input logic [31:0] s, input logic [31:0] e);
      compares++;
      if (s !== e) begin
         n_fail++;
         $display("Error at %0t: seen %h expected %h", $time, s, e);
      end
   endtask : check
   // Holds the request until pready is seen at an edge
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel_i <= 1'b1; pwrite_i <= w; paddr_i <= a; pwdata_i <= d; penable_i <= 1'b0;
      @(posedge clk_i);
      penable_i <= 1'b1;
      // Only the watchdog ends a wait that never sees pready
      do @(posedge clk_i); while (pready_o !== 1'b1);
      rd = prdata_o; err = pslverr_o;
      psel_i <= 1'b0; penable_i <= 1'b0;
      // Idle edge so a following setup never reassigns psel in the same step
      @(posedge clk_i);
   endtask : apb
   task cfg(input logic [15:0] g1, g2, g3, g4, f1, f2);
      logic [15:0] v [6];
      v = '{f1, f2, g1, g2, g3, g4};
      for (int i = 0; i < 6; i++) begin
         apb(1'b1, 12'(i * 4), {16'h0, v[i]});
         check(err, 1'b0);
      end
   endtask : cfg
   // Covers the worst input lag plus the model's own stage
   task see(input logic [15:0] d, input logic [15:0] g, input logic t);
      tgt <= d;
      repeat (6) @(posedge clk_i);
      check(speed_p_gain_o, g);
      check(table_active_o, t);
   endtask : see
   ////////////////////////////////////////////////////////////////
   task t_regs;
      for (int i = 0; i < 7; i++) begin
         apb(1'b0, 12'(i * 4), 32'h0);
         check(rd, (i < 6) ? 32'h0000_270F : 32'h0);
      end
      apb(1'b0, 12'h020, 32'h0);
      check(err, 1'b1);
      check(rd, 32'h0);
   endtask : t_regs
   task t_refuse;
      logic [11:0] a [7];
      logic [31:0] d [7];
      a = '{12'h008, 12'h008, 12'h000, 12'h000, 12'h004, 12'h01C, 12'h008};
      d = '{32'h3E9, 32'h3E8, 32'h0, 32'h64, 32'h63, 32'h0, 32'h1_0005};
      for (int i = 0; i < 7; i++) begin
         apb(1'b1, a[i], d[i]);
         check(err, !(i == 1 || i == 4));
      end
      apb(1'b0, 12'h008, 32'h0);
      check(rd, 32'h3E8);
   endtask : t_refuse
   task t_base;
      cfg(16'd50, 16'h270F, 16'h270F, 16'h270F, 16'h270F, 16'h270F);
      see(16'd200, base_proportional_gain_i, 1'b0);
      apb(1'b1, 12'h018, 32'h1);
      see(16'd200, second_base_proportional_gain_i, 1'b0);
      apb(1'b1, 12'h018, 32'h0);
   endtask : t_base
   task sweep(input logic [15:0] f1, input logic [15:0] f2);
      logic [15:0] x1, x2;
      x1 = lo + (hi - lo) * ((f1 == 16'h270F) ? 33 : f1) / 100;
      x2 = lo + (hi - lo) * ((f2 == 16'h270F) ? 66 : f2) / 100;
      cfg(16'd10, 16'd20, 16'h270F, 16'd40, f1, f2);
      see(x1 - 16'd1, 16'd10, 1'b1);
      see(x1, 16'd20, 1'b1);
      see(x2, 16'd20, 1'b1);
      see(x2 + 16'd1, 16'd40, 1'b1);
   endtask : sweep
   task t_zones;
      sweep(16'h270F, 16'h270F);
      sweep(16'd25, 16'd75);
      cfg(16'h270F, 16'd20, 16'h270F, 16'd40, 16'd25, 16'd75);
      see(16'd100, 16'd20, 1'b1);
      cfg(16'd10, 16'd20, 16'd70, 16'd40, 16'd50, 16'd50);
      see(16'd200, 16'd70, 1'b1);
      cfg(16'd10, 16'd70, 16'd20, 16'd40, 16'd50, 16'd50);
      see(16'd200, 16'd70, 1'b1);
      // Status: mid zone, four set (count wraps to zero), enough, table on, gain 70
      apb(1'b0, 12'h01C, 32'h0);
      check(rd, 32'h0043_0046);
   endtask : t_zones
   task t_mode;
      cfg(16'd10, 16'd20, 16'h270F, 16'd40, 16'd25, 16'd75);
      for (int m = 2; m >= 0; m--) begin
         ctl_mode_i <= dbgs_ctl_mode_t'(m);
         see(16'd200, (m == 0) ? base_proportional_gain_i : 16'd20, m != 0);
      end
      // Forced vector mode lets the table act while the mode input says other
      apb(1'b1, 12'h018, 32'h2);
      see(16'd200, 16'd20, 1'b1);
      apb(1'b1, 12'h018, 32'h0);
      see(16'd200, base_proportional_gain_i, 1'b0);
      ctl_mode_i <= DBGS_CTL_VECTOR;
   endtask : t_mode
   task t_pin;
      for (int k = 0; k < 4; k++) begin
         cen <= k[1];
         gain_table_disable_input_i <= k[0];
         see(16'd200, (k == 2) ? 16'd20 : base_proportional_gain_i, k == 2);
      end
   endtask : t_pin
   ////////////////////////////////////////////////////////////////
   task give_verdict;
      if (n_fail == 0 && compares > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : give_verdict
   initial begin
      repeat (20000) @(posedge clk_i);
      n_fail++;
      give_verdict;
   end
   initial begin
      {nrst_i, psel_i, penable_i, pwrite_i, paddr_i, pwdata_i, gain_table_disable_input_i} = '0;
      {cen, tgt, lo, hi} = {1'b1, 16'd200, 16'd100, 16'd300};
      base_proportional_gain_i = 16'h0123;
      second_base_proportional_gain_i = 16'h0456;
      ctl_mode_i = DBGS_CTL_VECTOR;
      repeat (5) @(posedge clk_i);
      nrst_i <= 1'b1;
      @(posedge clk_i);
      t_regs;
      t_refuse;
      t_base;
      t_zones;
      t_mode;
      t_pin;
      give_verdict;
   end
endmodule : test_dbgs_top
bind dbgs_top dbgs_chk u_chk (
   .clk_i                           (clk_i),
   .nrst_i                          (nrst_i),
   .psel_i                          (psel_i),
   .penable_i                       (penable_i),
   .pwrite_i                        (pwrite_i),
   .paddr_i                         (paddr_i),
   .pwdata_i                        (pwdata_i),
   .prdata_o                        (prdata_o),
   .pready_o                        (pready_o),
   .pslverr_o                       (pslverr_o),
   .diam_calc_en_i                  (diam_calc_en_i),
   .base_proportional_gain_i        (base_proportional_gain_i),
   .second_base_proportional_gain_i (second_base_proportional_gain_i),
   .gain_table_disable_input_i      (gain_table_disable_input_i),
   .speed_p_gain_o                  (speed_p_gain_o),
   .table_active_o                  (table_active_o)
);
`default_nettype wire
